// File: rtl/badc_pkg.sv
// badc_pkg: constants and types for the bank #1 ambient and dropout control block
// assumes a 40 MHz core clock and an external I2C slave that turns bus cycles into strobes
package badc_pkg;

   // register offsets on the internal register port
   localparam logic [7:0] BADC_ENABLE_OFF = 8'h01;
   localparam logic [7:0] BADC_RISE_OFF = 8'h14;
   localparam logic [7:0] BADC_FALL_OFF = 8'h15;
   localparam logic [7:0] BADC_CTRL_OFF = 8'h16;

   // field positions of the dropout and effects control register
   localparam int BADC_ACT_BIT = 6;
   localparam int BADC_RATE_BIT = 5;
   localparam int BADC_DPEN_BIT = 4;
   localparam int BADC_EFF_LSB = 1;
   localparam int BADC_BYP_BIT = 0;

   // field positions in the enable register
   localparam int BADC_BANK1_EN_BIT = 0;
   localparam int BADC_GLOBAL_EN_BIT = 1;
   localparam int BADC_LIGHTS_OFF_BIT = 2;

   // reset values
   localparam logic [7:0] BADC_RISE_RST = 8'h00;
   localparam logic [7:0] BADC_FALL_RST = 8'h00;
   localparam logic [2:0] BADC_EFF_RST = 3'h0;

   // effect codes
   localparam logic [2:0] BADC_EFF_DIM_FULL = 3'h1;
   localparam logic [2:0] BADC_EFF_DIM_PART = 3'h2;

   // timing
   localparam int unsigned BADC_CLK_MHZ = 40;
   localparam int unsigned BADC_SLOW_FIRST_NS = 4000000;
   localparam int unsigned BADC_SLOW_STEP_NS = 1000000;
   localparam int unsigned BADC_FAST_FIRST_NS = 256000;
   localparam int unsigned BADC_FAST_STEP_NS = 64000;
   localparam int unsigned BADC_SLOW_FIRST_CYC = BADC_SLOW_FIRST_NS * BADC_CLK_MHZ / 1000;
   localparam int unsigned BADC_SLOW_STEP_CYC = BADC_SLOW_STEP_NS * BADC_CLK_MHZ / 1000;
   localparam int unsigned BADC_FAST_FIRST_CYC = BADC_FAST_FIRST_NS * BADC_CLK_MHZ / 1000;
   localparam int unsigned BADC_FAST_STEP_CYC = BADC_FAST_STEP_NS * BADC_CLK_MHZ / 1000;
   localparam int BADC_TMR_W = 18;
   localparam int BADC_LVL_W = 5;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } badc_req_t;

   // writable fields of the control register
   typedef struct packed {
      logic rate;
      logic dp_en;
      logic [2:0] effect;
      logic bypass;
   } badc_ctrl_t;

   // dropout sequencer states
   typedef enum logic [1:0] {
      DO_IDLE = 2'b00,
      DO_FIRST = 2'b01,
      DO_STEP = 2'b10,
      DO_HOLD = 2'b11
   } badc_do_state_t;

endpackage : badc_pkg

// File: rtl/badc_step_timer.sv
// badc_step_timer: one-shot down counter for the dropout step delays
// assumes load_i is a one-cycle pulse on the core clock
`timescale 1ns/1ps
module badc_step_timer (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic load_i,
   input wire logic [badc_pkg::BADC_TMR_W-1:0] load_val_i,
   output logic expired_o
);
   import badc_pkg::*;

   logic [BADC_TMR_W-1:0] cnt_q;
   logic run_q;
   logic expired_q;
   wire last_w = run_q && (cnt_q == '0);

   // reload restarts the count, so a stale expiry never follows a new load
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         expired_q <= 1'b0;
      end else begin
         expired_q <= last_w && !load_i;
         if (load_i) begin
            cnt_q <= load_val_i - 1'b1;
            run_q <= 1'b1;
         end else if (last_w) begin
            run_q <= 1'b0;
         end else if (run_q) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   assign expired_o = expired_q;

endmodule : badc_step_timer

// File: rtl/badc_ctrl.sv
// badc_ctrl: bank #1 ambient threshold selection and dropout protection sequencing
// assumes an I2C slave outside feeds one-cycle register strobes on core_clk_i,
// ambient codes arrive from same-clock logic, analog status lines are asynchronous
`timescale 1ns/1ps

module badc_ctrl #(
   parameter int unsigned SLOW_FIRST_CYC = badc_pkg::BADC_SLOW_FIRST_CYC,
   parameter int unsigned SLOW_STEP_CYC = badc_pkg::BADC_SLOW_STEP_CYC,
   parameter int unsigned FAST_FIRST_CYC = badc_pkg::BADC_FAST_FIRST_CYC
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire badc_pkg::badc_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   input wire logic ambient_auto_i,
   input wire logic [7:0] ambient_code_i,
   input wire logic ambient_code_stb_i,
   input wire logic [badc_pkg::BADC_LVL_W-1:0] bank1_start_i,
   input wire logic [badc_pkg::BADC_LVL_W-1:0] bank1_target_i,
   input wire logic supply_low_i,
   input wire logic bank1_sink_float_i,
   input wire logic duty_pin_i,
   output logic [badc_pkg::BADC_LVL_W-1:0] bank1_level_o,
   output logic bank1_at_target_o,
   output logic dropout_limit_active_o,
   output logic duty_level_o,
   output logic duty_input_ignore_o,
   output logic autodim_full_req_o,
   output logic autodim_partial_req_o
);
   import badc_pkg::*;

   localparam int unsigned FAST_STEP_CYC = BADC_FAST_STEP_CYC;
   localparam logic [BADC_TMR_W-1:0] SLOW_FIRST_LD = BADC_TMR_W'(SLOW_FIRST_CYC);
   localparam logic [BADC_TMR_W-1:0] SLOW_STEP_LD = BADC_TMR_W'(SLOW_STEP_CYC);
   localparam logic [BADC_TMR_W-1:0] FAST_FIRST_LD = BADC_TMR_W'(FAST_FIRST_CYC);
   localparam logic [BADC_TMR_W-1:0] FAST_STEP_LD = BADC_TMR_W'(FAST_STEP_CYC);

   function automatic logic hit(input badc_req_t req, input logic [7:0] off);
      hit = (req.addr == off);
   endfunction : hit

   // pin synchronisers: supply low, sink float, duty pin
   logic [2:0] pin_async_w;
   logic [2:0] pin_sync_w;
   assign pin_async_w = {duty_pin_i, bank1_sink_float_i, supply_low_i};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         logic meta_q;
         logic sync_q;
         always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= pin_async_w[gi];
               sync_q <= meta_q;
            end
         end
         assign pin_sync_w[gi] = sync_q;
      end
   endgenerate

   wire supply_low_w = pin_sync_w[0];
   wire sink_float_w = pin_sync_w[1];
   wire duty_pin_w = pin_sync_w[2];

   // register decode
   wire wr_rise_w = reg_req_i.wr && hit(reg_req_i, BADC_RISE_OFF);
   wire wr_fall_w = reg_req_i.wr && hit(reg_req_i, BADC_FALL_OFF);
   wire wr_ctrl_w = reg_req_i.wr && hit(reg_req_i, BADC_CTRL_OFF);
   wire wr_enable_w = reg_req_i.wr && hit(reg_req_i, BADC_ENABLE_OFF);

   // resume on enable write: bank #1 stays on with lights-off, global enable or both
   wire resume_wr_w = wr_enable_w && reg_req_i.wdata[BADC_BANK1_EN_BIT]
                      && (reg_req_i.wdata[BADC_LIGHTS_OFF_BIT] || reg_req_i.wdata[BADC_GLOBAL_EN_BIT]);

   logic [7:0] rise_q;
   logic [7:0] fall_q;
   badc_ctrl_t ctrl_q;
   badc_ctrl_t ctrl_d;
   logic act_q;

   // floating sink beats a software write of the enable bit
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl_w) begin
         ctrl_d.rate = reg_req_i.wdata[BADC_RATE_BIT];
         ctrl_d.dp_en = reg_req_i.wdata[BADC_DPEN_BIT];
         ctrl_d.effect = reg_req_i.wdata[BADC_EFF_LSB +: 3];
         ctrl_d.bypass = reg_req_i.wdata[BADC_BYP_BIT];
      end
      if (sink_float_w) begin
         ctrl_d.dp_en = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rise_q <= BADC_RISE_RST;
         fall_q <= BADC_FALL_RST;
         ctrl_q <= '0;
      end else begin
         if (wr_rise_w) rise_q <= reg_req_i.wdata;
         if (wr_fall_w) fall_q <= reg_req_i.wdata;
         ctrl_q <= ctrl_d;
      end
   end

   // read-back: bit 7 of the control register reads zero, unmapped reads zero
   wire [7:0] ctrl_rd_w = {1'b0, act_q, ctrl_q.rate, ctrl_q.dp_en, ctrl_q.effect, ctrl_q.bypass};
   wire [7:0] rd_mux_w = hit(reg_req_i, BADC_RISE_OFF) ? rise_q :
                         hit(reg_req_i, BADC_FALL_OFF) ? fall_q :
                         hit(reg_req_i, BADC_CTRL_OFF) ? ctrl_rd_w : 8'h00;
   logic [7:0] rdata_q;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) rdata_q <= 8'h00;
      else if (reg_req_i.rd) rdata_q <= rd_mux_w;
   end
   assign reg_rdata_o = rdata_q;

   // ambient threshold compare
   wire hyst_off_w = (fall_q >= rise_q);
   wire above_w = (ambient_code_i > rise_q);
   wire below_w = hyst_off_w ? (ambient_code_i < rise_q) : (ambient_code_i < fall_q);
   wire eval_w = ambient_auto_i && ambient_code_stb_i;

   logic at_target_q;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         at_target_q <= 1'b0;
      end else if (eval_w) begin
         if (above_w) at_target_q <= 1'b1;
         else if (below_w) at_target_q <= 1'b0;
      end
   end

   // auto off holds bank #1 at its start setting, whatever the ambient code does
   wire [BADC_LVL_W-1:0] base_w = (ambient_auto_i && at_target_q) ? bank1_target_i : bank1_start_i;

   // dropout sequencer; only bank #1's level is ever reduced
   badc_do_state_t st_q;
   badc_do_state_t st_d;
   logic [BADC_LVL_W-1:0] red_q;
   logic tmr_exp_w;

   wire resume_w = !ctrl_q.dp_en || sink_float_w || resume_wr_w;
   wire room_w = (red_q < base_w);
   wire [BADC_TMR_W-1:0] first_ld_w = ctrl_q.rate ? SLOW_FIRST_LD : FAST_FIRST_LD;
   wire [BADC_TMR_W-1:0] step_ld_w = ctrl_q.rate ? SLOW_STEP_LD : FAST_STEP_LD;

   logic tmr_load_w;
   logic [BADC_TMR_W-1:0] tmr_val_w;
   logic step_w;

   always_comb begin
      st_d = st_q;
      tmr_load_w = 1'b0;
      tmr_val_w = step_ld_w;
      step_w = 1'b0;
      unique case (st_q)
         DO_IDLE: begin
            if (!resume_w && supply_low_w) begin
               tmr_load_w = 1'b1;
               tmr_val_w = first_ld_w;
               st_d = DO_FIRST;
            end
         end
         DO_FIRST: begin
            if (resume_w) begin
               st_d = DO_IDLE;
            end else if (tmr_exp_w) begin
               if (supply_low_w) begin
                  step_w = room_w;
                  tmr_load_w = 1'b1;
                  st_d = DO_STEP;
               end else begin
                  st_d = DO_IDLE;
               end
            end
         end
         DO_STEP: begin
            if (resume_w) begin
               st_d = DO_IDLE;
            end else if (tmr_exp_w) begin
               if (supply_low_w) begin
                  step_w = room_w;
                  tmr_load_w = 1'b1;
               end else begin
                  st_d = DO_HOLD;
               end
            end
         end
         DO_HOLD: begin
            if (resume_w) begin
               st_d = DO_IDLE;
            end else if (supply_low_w) begin
               tmr_load_w = 1'b1;
               st_d = DO_STEP;
            end
         end
      endcase
   end

   badc_step_timer u_timer (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(tmr_load_w),
      .load_val_i(tmr_val_w),
      .expired_o(tmr_exp_w)
   );

   // step and resume cannot meet: every step path excludes resume_w
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= DO_IDLE;
         red_q <= '0;
         act_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (step_w) begin
            red_q <= red_q + 1'b1;
            act_q <= 1'b1;
         end else if (resume_w) begin
            red_q <= '0;
            act_q <= 1'b0;
         end
      end
   end

   // level output saturates at zero
   logic [BADC_LVL_W-1:0] level_q;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) level_q <= '0;
      else level_q <= room_w ? (base_w - red_q) : '0;
   end

   // effect requests and duty pin handling, all registered
   logic full_q;
   logic part_q;
   logic duty_q;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         full_q <= 1'b0;
         part_q <= 1'b0;
         duty_q <= 1'b1;
      end else begin
         full_q <= (ctrl_q.effect == BADC_EFF_DIM_FULL);
         part_q <= (ctrl_q.effect == BADC_EFF_DIM_PART);
         duty_q <= ctrl_q.bypass ? 1'b1 : duty_pin_w;
      end
   end

   assign bank1_level_o = level_q;
   assign bank1_at_target_o = at_target_q;
   assign dropout_limit_active_o = act_q;
   assign duty_level_o = duty_q;
   assign duty_input_ignore_o = ctrl_q.bypass;
   assign autodim_full_req_o = full_q;
   assign autodim_partial_req_o = part_q;

endmodule : badc_ctrl

// File: sim/badc_chk_asserts.sv
// badc_chk: port-level checks for badc_ctrl
// assumes it is bound onto badc_ctrl; threshold shadows follow host writes
`timescale 1ns/1ps
module badc_chk (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire badc_pkg::badc_req_t reg_req_i,
   input wire logic ambient_auto_i,
   input wire logic [7:0] ambient_code_i,
   input wire logic ambient_code_stb_i,
   input wire logic [badc_pkg::BADC_LVL_W-1:0] bank1_start_i,
   input wire logic bank1_sink_float_i,
   input wire logic [badc_pkg::BADC_LVL_W-1:0] bank1_level_o,
   input wire logic bank1_at_target_o,
   input wire logic dropout_limit_active_o,
   input wire logic duty_level_o,
   input wire logic duty_input_ignore_o,
   input wire logic autodim_full_req_o,
   input wire logic autodim_partial_req_o
);
   import badc_pkg::*;
   logic [7:0] rise_q;
   logic [7:0] fall_q;
   wire wr_ctrl = reg_req_i.wr && reg_req_i.addr == BADC_CTRL_OFF;
   wire wr_en = reg_req_i.wr && reg_req_i.addr == BADC_ENABLE_OFF;
   wire resume = wr_en && reg_req_i.wdata[0] && (reg_req_i.wdata[1] || reg_req_i.wdata[2]);
   wire hyst = fall_q < rise_q;
   wire amb = ambient_code_stb_i && ambient_auto_i;
   wire [2:0] eff = reg_req_i.wdata[3:1];
   // shadows only; reads never feed them, so a broken read path stays visible
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rise_q <= BADC_RISE_RST;
         fall_q <= BADC_FALL_RST;
      end else begin
         if (reg_req_i.wr && reg_req_i.addr == BADC_RISE_OFF) rise_q <= reg_req_i.wdata;
         if (reg_req_i.wr && reg_req_i.addr == BADC_FALL_OFF) fall_q <= reg_req_i.wdata;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   amb_rise_a: assert property (amb && ambient_code_i > rise_q |=> bank1_at_target_o)
      else $error("target not chosen above rise");
   amb_fall_a: assert property (amb && ambient_code_i < (hyst ? fall_q : rise_q) |=> !bank1_at_target_o)
      else $error("start not chosen below threshold");
   amb_hold_a: assert property (amb && ambient_code_i <= rise_q && ambient_code_i >= (hyst ? fall_q : rise_q)
      |=> $stable(bank1_at_target_o)) else $error("selection moved inside band");
   eff_full_a: assert property (wr_ctrl && eff == BADC_EFF_DIM_FULL |-> ##2 autodim_full_req_o && !autodim_partial_req_o)
      else $error("full auto-dim request wrong");
   eff_none_a: assert property (wr_ctrl && eff != BADC_EFF_DIM_FULL && eff != BADC_EFF_DIM_PART
      |-> ##2 !autodim_full_req_o && !autodim_partial_req_o) else $error("effect request for reserved code");
   duty_byp_a: assert property (duty_input_ignore_o && $past(duty_input_ignore_o) |-> duty_level_o)
      else $error("duty pin not ignored");
   act_off_a: assert property (wr_ctrl && !reg_req_i.wdata[BADC_DPEN_BIT] |-> ##2 !dropout_limit_active_o)
      else $error("active flag kept with protection off");
   act_resume_a: assert property (resume |-> ##2 !dropout_limit_active_o ##1 (ambient_auto_i || bank1_level_o == bank1_start_i))
      else $error("resume write did not restore");
   float_clr_a: assert property (bank1_sink_float_i [*5] |-> !dropout_limit_active_o)
      else $error("active flag kept with floating sink");
   act_step_a: assert property ($rose(dropout_limit_active_o) && !ambient_auto_i |-> ##[0:2] bank1_level_o < bank1_start_i)
      else $error("active flag without reduction");
   level_cap_a: assert property ($past(!ambient_auto_i) && $stable(bank1_start_i) |-> bank1_level_o <= bank1_start_i)
      else $error("level above programmed start");
   cover property (amb ##1 bank1_at_target_o);
   cover property ($rose(dropout_limit_active_o));
   cover property (resume ##2 $fell(dropout_limit_active_o));
endmodule : badc_chk

bind badc_ctrl badc_chk i_badc_chk (
   .core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i),
   .reg_req_i(reg_req_i),
   .ambient_auto_i(ambient_auto_i),
   .ambient_code_i(ambient_code_i),
   .ambient_code_stb_i(ambient_code_stb_i),
   .bank1_start_i(bank1_start_i),
   .bank1_sink_float_i(bank1_sink_float_i),
   .bank1_level_o(bank1_level_o),
   .bank1_at_target_o(bank1_at_target_o),
   .dropout_limit_active_o(dropout_limit_active_o),
   .duty_level_o(duty_level_o),
   .duty_input_ignore_o(duty_input_ignore_o),
   .autodim_full_req_o(autodim_full_req_o),
   .autodim_partial_req_o(autodim_partial_req_o)
);

// File: sim/badc_host.sv
// badc_host: host side of the register port, one-cycle strobes
// assumes one caller at a time on the core clock
`timescale 1ns/1ps
module badc_host (
   input wire logic core_clk_i,
   input wire logic [7:0] reg_rdata_i,
   output badc_pkg::badc_req_t reg_req_o
);
   import badc_pkg::*;
   initial reg_req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      #1 reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk_i);
      // released lines move, so a stale value cannot pass
      #1 reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      #1 reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~a};
      @(posedge core_clk_i);
      #1 reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~a};
      @(posedge core_clk_i);
      #1 d = reg_rdata_i;
   endtask : rd
endmodule : badc_host

// File: sim/tb_bank1_ambient_dropout_control.sv
// tb_bank1_ambient_dropout_control: register, ambient and dropout tests
// assumes shortened slow delays; the fast step keeps its full length
`timescale 1ns/1ps
module tb_bank1_ambient_dropout_control;
   import badc_pkg::*;
   localparam int SF = 40;
   localparam int SS = 10;
   localparam int FF = 16;
   localparam logic [4:0] ST = 5'h0a;
   localparam logic [4:0] TG = 5'h1c;
   localparam logic [7:0] RES [3] = '{8'h03, 8'h05, 8'h07};
   logic clk, rst, auto, stb, slow, flt, pin, at_t, act, duty, ign, full, part;
   logic [7:0] code;
   logic [7:0] rdata;
   logic [4:0] level;
   badc_req_t req;
   int mismatches = 0;
   int n_tests = 0;
   badc_ctrl #(.SLOW_FIRST_CYC(SF), .SLOW_STEP_CYC(SS), .FAST_FIRST_CYC(FF)) i_badc_ctrl (
      .core_clk_i(clk), .sys_rst_i(rst), .reg_req_i(req), .reg_rdata_o(rdata), .ambient_auto_i(auto),
      .ambient_code_i(code), .ambient_code_stb_i(stb), .bank1_start_i(ST), .bank1_target_i(TG),
      .supply_low_i(slow), .bank1_sink_float_i(flt), .duty_pin_i(pin), .bank1_level_o(level),
      .bank1_at_target_o(at_t), .dropout_limit_active_o(act), .duty_level_o(duty),
      .duty_input_ignore_o(ign), .autodim_full_req_o(full), .autodim_partial_req_o(part));
   badc_host i_badc_host (.core_clk_i(clk), .reg_rdata_i(rdata), .reg_req_o(req));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic close_out;
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_badc_host.rd(a, d);
      chk(d, e);
   endtask : rdchk
   task automatic pulse(input logic [7:0] c);
      cyc(1);
      code = c;
      stb = 1'b1;
      cyc(1);
      stb = 1'b0;
      cyc(3);
   endtask : pulse
   task automatic amb(input logic [7:0] c, input logic t);
      pulse(c);
      chk({2'h0, at_t, level}, {2'h0, t, t ? TG : ST});
   endtask : amb
   // bounded wait for the level to leave b, result in cycles
   task automatic wait_drop(input logic [4:0] b, output int n);
      n = 0;
      // look just after each edge, never in the edge's own time step
      while (level === b && n < 300) begin
         cyc(1);
         n++;
      end
   endtask : wait_drop
   initial begin
      #(25 * 20000);
      mismatches++;
      close_out;
   end
   initial begin
      int n;
      logic [4:0] lv;
      {auto, stb, slow, flt, pin, code} = '0;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      rdchk(BADC_RISE_OFF, 8'h00);
      rdchk(BADC_FALL_OFF, 8'h00);
      rdchk(BADC_CTRL_OFF, 8'h00);
      i_badc_host.wr(BADC_RISE_OFF, 8'ha5);
      i_badc_host.wr(BADC_CTRL_OFF, 8'hcf);
      rdchk(BADC_RISE_OFF, 8'ha5);
      rdchk(BADC_CTRL_OFF, 8'h0f);
      rdchk(8'h20, 8'h00);
      chk({5'h0, full, part, ign & duty}, 8'h01);
      for (int c = 0; c < 8; c++) begin
         i_badc_host.wr(BADC_CTRL_OFF, 8'(c << 1));
         cyc(2);
         chk({6'h0, full, part}, {6'h0, c == 1, c == 2});
      end
      cyc(4);
      chk({6'h0, ign, duty}, 8'h00);
      pin = 1'b1;
      cyc(4);
      chk({6'h0, ign, duty}, 8'h01);
      i_badc_host.wr(BADC_RISE_OFF, 8'h80);
      i_badc_host.wr(BADC_FALL_OFF, 8'h40);
      auto = 1'b1;
      amb(8'h81, 1'b1);
      amb(8'h40, 1'b1);
      amb(8'h3f, 1'b0);
      amb(8'h80, 1'b0);
      i_badc_host.wr(BADC_FALL_OFF, 8'h90);
      amb(8'h81, 1'b1);
      amb(8'h80, 1'b1);
      amb(8'h7f, 1'b0);
      auto = 1'b0;
      pulse(8'hff);
      chk({2'h0, at_t, level}, {3'h0, ST});
      slow = 1'b1;
      i_badc_host.wr(BADC_CTRL_OFF, 8'h30);
      wait_drop(ST, n);
      chk({7'h0, n >= SF && n <= SF + 6}, 8'h01);
      chk({3'h0, level}, {3'h0, ST - 5'h01});
      wait_drop(ST - 5'h01, n);
      chk({7'h0, n >= SS && n <= SS + 2}, 8'h01);
      rdchk(BADC_CTRL_OFF, 8'h70);
      slow = 1'b0;
      lv = level;
      cyc(SS * 4);
      chk({3'h0, level}, {3'h0, lv});
      // supply low again from hold: stepping resumes at the quarter delay
      slow = 1'b1;
      wait_drop(lv, n);
      chk({7'h0, n >= SS && n <= SS + 6}, 8'h01);
      // host clears the enable to get the original current back
      i_badc_host.wr(BADC_CTRL_OFF, 8'h20);
      cyc(3);
      chk({2'h0, act, level}, {3'h0, ST});
      slow = 1'b1;
      i_badc_host.wr(BADC_CTRL_OFF, 8'h10);
      wait_drop(ST, n);
      chk({7'h0, n >= FF && n <= FF + 6}, 8'h01);
      i_badc_host.wr(BADC_ENABLE_OFF, 8'h01);
      chk({7'h0, act}, 8'h01);
      for (int i = 0; i < 3; i++) begin
         i_badc_host.wr(BADC_ENABLE_OFF, RES[i]);
         cyc(3);
         chk({2'h0, act, level}, {3'h0, ST});
         wait_drop(ST, n);
      end
      chk({7'h0, act}, 8'h01);
      flt = 1'b1;
      cyc(6);
      chk({2'h0, act, level}, {3'h0, ST});
      rdchk(BADC_CTRL_OFF, 8'h00);
      flt = 1'b0;
      close_out;
   end
endmodule : tb_bank1_ambient_dropout_control
